// file: hw/flash_irq_pkg.sv
/*
 * Shared constants of the flash disk interrupt and output control block:
 * register byte addresses, field positions, reset values and timing.
 * Assumes a 20 MHz device clock and a 32-bit classic Wishbone slave port.
 */
package flash_irq_pkg;
    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 32;
    localparam int          SEL_W         = 4;
    localparam int          NUM_SRC       = 6;
    localparam int          NUM_EVT       = 3;
    localparam int          OC_W          = 3;
    localparam int          CNT_W         = 4;
    localparam int          SYNC_W        = 6;

    localparam logic [15:0] INT_CTRL_ADDR = 16'h1010;
    localparam logic [15:0] OUT_CTRL_ADDR = 16'h1014;
    localparam logic [15:0] INT_STAT_ADDR = 16'h1020;
    localparam logic [15:0] EVT_STAT_ADDR = 16'h1030;
    localparam logic [15:0] EVT_MASK_ADDR = 16'h1034;

    localparam int          ENABLE_LSB    = 0;
    localparam int          MASK_LSB      = 8;
    localparam int          EDGE_BIT      = 14;
    localparam int          GATE_BIT      = 15;
    localparam int          LOW_LANE      = 0;
    localparam int          HIGH_LANE     = 1;

    localparam int          OC_BUSY_BIT   = 0;
    localparam int          OC_PUDIS_BIT  = 1;
    localparam int          OC_TURBO_BIT  = 2;
    localparam logic [2:0]  OC_RESET      = 3'h1;

    localparam int          EVT_IRQ_BIT   = 0;
    localparam int          EVT_BOOT_BIT  = 1;
    localparam int          EVT_BAD_BIT   = 2;

    // Sync order: cascade[1:0], hw reset pin, if_cfg, oe, ce (idle levels)
    localparam logic [5:0]  SYNC_RESET    = 6'h0B;
    localparam int          SYNC_HWRST    = 3;
    localparam int          SYNC_IFCFG    = 2;
    localparam int          SYNC_OE       = 1;
    localparam int          SYNC_CE       = 0;
    localparam int          SYNC_CASC_LSB = 4;

    localparam int          CLK_PERIOD_NS = 50;
    localparam int          IRQ_PULSE_NS  = 100;
    localparam int          OUT_SETTLE_NS = 100;
    localparam int          IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SETTLE_CYC    = (OUT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_INT_CTRL,
        SEL_OUT_CTRL,
        SEL_INT_STAT,
        SEL_EVT_STAT,
        SEL_EVT_MASK
    } reg_sel_t;
endpackage : flash_irq_pkg

// file: hw/pin_sync.sv
/*
 * Three-stage synchroniser for asynchronous pins.
 * Assumes the pins may change at any time; a new level is accepted only
 * once the second and third stages agree.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int         W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         CLOCK_IN,
    input  wire logic         RESET_IN,
    input  wire logic [W-1:0] PIN_IN,
    output logic      [W-1:0] LEVEL_OUT
);
    logic [W-1:0] stage1_ff;
    logic [W-1:0] stage2_ff;
    logic [W-1:0] stage3_ff;

    // First stage feeds only the second, never any logic
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            stage1_ff <= RESET_VAL;
            stage2_ff <= RESET_VAL;
            stage3_ff <= RESET_VAL;
        end else begin
            stage1_ff <= PIN_IN;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
                if (RESET_IN) begin
                    LEVEL_OUT[i] <= RESET_VAL[i];
                end else if (stage2_ff[i] == stage3_ff[i]) begin
                    LEVEL_OUT[i] <= stage3_ff[i];
                end
            end
        end
    endgenerate
endmodule : pin_sync

// file: hw/flash_irq_ctrl.sv
/*
 * Interrupt controller and output control register of a flash disk device,
 * reached over a classic Wishbone slave port.
 * Assumes sources, mode reset and boot strobes come from logic on CLOCK_IN;
 * the hardware reset, interface, output-enable, chip-enable and cascade
 * pins arrive asynchronously and are synchronised here.
 */
`timescale 1ns/1ps
// What this block does
// - six sources feed status bits 0 to 5
// - enabled source latches status, mask raises interrupt
// - disabled source keeps its status at zero
// - mask bits 13-8 gate status onto pin
// - level mode holds pin until cleared
// - edge mode emits low pulse, then high
// - gate bit enables pin, pending fires at once
// - gate off forces pin negated
// - output control reset only by hardware reset
// - output control writes ignore cascade select
// - bit 0 gates busy during soft boot
// - hardware reset forces busy until download done
// - bit 1 disables upper pull-ups, else by pin
// - normal mode delays read buffer enable
// - turbo enables read buffers immediately
// - interrupt registers reset to zero
module flash_irq_ctrl
    import flash_irq_pkg::*;
(
    input  wire logic              CLOCK_IN,
    input  wire logic              RESET_IN,
    input  wire logic              WB_CYC_IN,
    input  wire logic              WB_STB_IN,
    input  wire logic              WB_WE_IN,
    input  wire logic [ADDR_W-1:0] WB_ADR_IN,
    input  wire logic [SEL_W-1:0]  WB_SEL_IN,
    input  wire logic [DATA_W-1:0] WB_DAT_IN,
    output logic      [DATA_W-1:0] WB_DAT_OUT,
    output logic                   WB_ACK_OUT,
    input  wire logic [NUM_SRC-1:0] SOURCE_IN,
    input  wire logic              MODE_RESET_IN,
    input  wire logic              SOFT_BOOT_START_IN,
    input  wire logic              BOOT_DONE_IN,
    input  wire logic [1:0]        DEVICE_ID_IN,
    input  wire logic              HARDWARE_RESET_PIN_N_IN,
    input  wire logic              IF_CFG_IN,
    input  wire logic              OE_N_IN,
    input  wire logic              CE_N_IN,
    input  wire logic [1:0]        CASCADE_SELECT_PINS_IN,
    output logic                   IRQ_N_OUT,
    output logic                   BUSY_N_OUT,
    output logic                   PULLUP_EN_OUT,
    output logic                   READ_BUF_EN_OUT,
    output logic                   INT_OUT
);
    logic [SYNC_W-1:0]  pins_s;
    logic               hw_rst;
    logic               if_cfg;
    logic               rd_both;
    logic               id_match;
    logic               int_clear;
    logic               bus_req;
    logic               bus_wr;
    reg_sel_t           sel;
    logic [NUM_SRC-1:0] int_enable_ff;
    logic [NUM_SRC-1:0] int_mask_ff;
    logic               edge_sel_ff;
    logic               global_interrupt_gate_ff;
    logic [NUM_SRC-1:0] int_status_ff;
    logic [NUM_SRC-1:0] latch_want;
    logic               irq_req;
    logic               irq_req_d_ff;
    logic               req_rise;
    logic [CNT_W-1:0]   pulse_cnt_ff;
    logic               nxt_irq_n;
    logic [OC_W-1:0]    out_ctl_ff;
    logic               busy_active_ff;
    logic               hw_boot_ff;
    logic [CNT_W-1:0]   settle_cnt_ff;
    logic [NUM_EVT-1:0] evt_stat_ff;
    logic [NUM_EVT-1:0] evt_mask_ff;
    logic [NUM_EVT-1:0] evt_set;
    logic [DATA_W-1:0]  rd_value;

    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] adr);
        reg_sel_t s;
        s = SEL_NONE;
        if (adr[ADDR_W-1:2] == INT_CTRL_ADDR[ADDR_W-1:2]) s = SEL_INT_CTRL;
        if (adr[ADDR_W-1:2] == OUT_CTRL_ADDR[ADDR_W-1:2]) s = SEL_OUT_CTRL;
        if (adr[ADDR_W-1:2] == INT_STAT_ADDR[ADDR_W-1:2]) s = SEL_INT_STAT;
        if (adr[ADDR_W-1:2] == EVT_STAT_ADDR[ADDR_W-1:2]) s = SEL_EVT_STAT;
        if (adr[ADDR_W-1:2] == EVT_MASK_ADDR[ADDR_W-1:2]) s = SEL_EVT_MASK;
        return s;
    endfunction : decode

    pin_sync #(
        .W         (SYNC_W),
        .RESET_VAL (SYNC_RESET)
    ) u_pin_sync (
        .CLOCK_IN  (CLOCK_IN),
        .RESET_IN  (RESET_IN),
        .PIN_IN    ({CASCADE_SELECT_PINS_IN, HARDWARE_RESET_PIN_N_IN, IF_CFG_IN,
                     OE_N_IN, CE_N_IN}),
        .LEVEL_OUT (pins_s)
    );

    assign hw_rst    = ~pins_s[SYNC_HWRST];
    assign if_cfg    = pins_s[SYNC_IFCFG];
    assign rd_both   = ~pins_s[SYNC_OE] & ~pins_s[SYNC_CE];
    assign id_match  = (pins_s[SYNC_CASC_LSB +: 2] == DEVICE_ID_IN);
    // Reset mode clears the interrupt side; output control survives it
    assign int_clear = hw_rst | MODE_RESET_IN;
    assign bus_req   = WB_CYC_IN & WB_STB_IN;
    // Writes land on the edge that the master sees ack
    assign bus_wr    = bus_req & WB_WE_IN & WB_ACK_OUT;
    assign sel       = decode(WB_ADR_IN);

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            WB_ACK_OUT <= 1'b0;
        end else begin
            WB_ACK_OUT <= bus_req & ~WB_ACK_OUT;
        end
    end

    always_comb begin
        rd_value = '0;
        case (sel)
            SEL_INT_CTRL: begin
                if (id_match) begin
                    rd_value[ENABLE_LSB +: NUM_SRC] = int_enable_ff;
                    rd_value[MASK_LSB +: NUM_SRC]   = int_mask_ff;
                    rd_value[EDGE_BIT]              = edge_sel_ff;
                    rd_value[GATE_BIT]              = global_interrupt_gate_ff;
                end
            end
            SEL_OUT_CTRL: rd_value[OC_W-1:0] = out_ctl_ff;
            SEL_INT_STAT: begin
                if (id_match) begin
                    rd_value[NUM_SRC-1:0] = int_status_ff;
                end
            end
            SEL_EVT_STAT: rd_value[NUM_EVT-1:0] = evt_stat_ff;
            SEL_EVT_MASK: rd_value[NUM_EVT-1:0] = evt_mask_ff;
            default:      rd_value = '0;
        endcase
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            WB_DAT_OUT <= '0;
        end else if (bus_req & ~WB_ACK_OUT) begin
            WB_DAT_OUT <= rd_value;
        end
    end

    // Other devices in a cascade ignore interrupt register writes
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            int_enable_ff            <= '0;
            int_mask_ff              <= '0;
            edge_sel_ff              <= 1'b0;
            global_interrupt_gate_ff <= 1'b0;
        end else if (int_clear) begin
            int_enable_ff            <= '0;
            int_mask_ff              <= '0;
            edge_sel_ff              <= 1'b0;
            global_interrupt_gate_ff <= 1'b0;
        end else if (bus_wr && sel == SEL_INT_CTRL && id_match) begin
            if (WB_SEL_IN[LOW_LANE]) begin
                int_enable_ff <= WB_DAT_IN[ENABLE_LSB +: NUM_SRC];
            end
            if (WB_SEL_IN[HIGH_LANE]) begin
                int_mask_ff              <= WB_DAT_IN[MASK_LSB +: NUM_SRC];
                edge_sel_ff              <= WB_DAT_IN[EDGE_BIT];
                global_interrupt_gate_ff <= WB_DAT_IN[GATE_BIT];
            end
        end
    end

    // Status is cleared only by dropping enable or by int_clear; writes to it are ignored,
    // so a source held active re-latches as soon as enable returns
    assign latch_want = int_enable_ff & SOURCE_IN;
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            int_status_ff <= '0;
        end else if (int_clear) begin
            int_status_ff <= '0;
        end else begin
            int_status_ff <= (int_status_ff | SOURCE_IN) & int_enable_ff;
        end
    end

    assign irq_req  = global_interrupt_gate_ff & |(int_status_ff & int_mask_ff);
    assign req_rise = irq_req & ~irq_req_d_ff;

    always_comb begin
        if (!global_interrupt_gate_ff) begin
            nxt_irq_n = 1'b1;
        end else if (edge_sel_ff) begin
            nxt_irq_n = ~(req_rise | (pulse_cnt_ff != '0));
        end else begin
            nxt_irq_n = ~irq_req;
        end
    end

    // A new rise during a pulse restarts it rather than being lost
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            irq_req_d_ff <= 1'b0;
            pulse_cnt_ff <= '0;
            IRQ_N_OUT    <= 1'b1;
        end else begin
            irq_req_d_ff <= irq_req;
            IRQ_N_OUT    <= nxt_irq_n;
            if (req_rise && edge_sel_ff) begin
                pulse_cnt_ff <= CNT_W'(IRQ_PULSE_CYC - 1);
            end else if (pulse_cnt_ff != '0) begin
                pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
            end
        end
    end

    // Written by any device of a cascade, kept through Reset mode
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            out_ctl_ff <= OC_RESET;
        end else if (hw_rst) begin
            out_ctl_ff <= OC_RESET;
        end else if (bus_wr && sel == SEL_OUT_CTRL && WB_SEL_IN[LOW_LANE]) begin
            out_ctl_ff <= WB_DAT_IN[OC_W-1:0];
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            busy_active_ff <= 1'b0;
            hw_boot_ff     <= 1'b0;
        end else if (hw_rst) begin
            busy_active_ff <= 1'b1;
            hw_boot_ff     <= 1'b1;
        end else if (BOOT_DONE_IN) begin
            busy_active_ff <= 1'b0;
            hw_boot_ff     <= 1'b0;
        end else if (SOFT_BOOT_START_IN) begin
            busy_active_ff <= 1'b1;
            hw_boot_ff     <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            BUSY_N_OUT <= 1'b1;
        end else begin
            BUSY_N_OUT <= ~(busy_active_ff & (hw_boot_ff | out_ctl_ff[OC_BUSY_BIT]));
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            PULLUP_EN_OUT <= 1'b0;
        end else begin
            PULLUP_EN_OUT <= ~out_ctl_ff[OC_PUDIS_BIT] & ~if_cfg;
        end
    end

    // Normal mode waits for the array data to settle before driving
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            settle_cnt_ff   <= '0;
            READ_BUF_EN_OUT <= 1'b0;
        end else begin
            if (!rd_both) begin
                settle_cnt_ff <= '0;
            end else if (settle_cnt_ff != CNT_W'(SETTLE_CYC)) begin
                settle_cnt_ff <= settle_cnt_ff + 1'b1;
            end
            READ_BUF_EN_OUT <= rd_both & (out_ctl_ff[OC_TURBO_BIT]
                               | (settle_cnt_ff == CNT_W'(SETTLE_CYC)));
        end
    end

    assign evt_set[EVT_IRQ_BIT]  = req_rise;
    assign evt_set[EVT_BOOT_BIT] = BOOT_DONE_IN & busy_active_ff;
    assign evt_set[EVT_BAD_BIT]  = bus_req & ~WB_ACK_OUT & (sel == SEL_NONE);

    // A new event outranks a write-one clear in the same cycle
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            evt_stat_ff <= '0;
        end else if (bus_wr && sel == SEL_EVT_STAT && WB_SEL_IN[LOW_LANE]) begin
            evt_stat_ff <= (evt_stat_ff & ~WB_DAT_IN[NUM_EVT-1:0]) | evt_set;
        end else begin
            evt_stat_ff <= evt_stat_ff | evt_set;
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            evt_mask_ff <= '0;
            INT_OUT     <= 1'b0;
        end else begin
            if (bus_wr && sel == SEL_EVT_MASK && WB_SEL_IN[LOW_LANE]) begin
                evt_mask_ff <= WB_DAT_IN[NUM_EVT-1:0];
            end
            INT_OUT <= |(evt_stat_ff & evt_mask_ff);
        end
    end

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);

    AST_STATUS_HELD: assert property (
        1'b1 |=> ((int_status_ff & ~$past(int_enable_ff)) == '0))
        else $error("status bit set while its enable was low");
    AST_STATUS_LATCH: assert property (
        !int_clear |=> (($past(latch_want) & ~int_status_ff) == '0))
        else $error("enabled source activity not latched");
    AST_GATE_OFF: assert property (
        !global_interrupt_gate_ff |=> IRQ_N_OUT)
        else $error("interrupt asserted with gate off");
    AST_LEVEL_HOLD: assert property (
        irq_req && !edge_sel_ff |=> !IRQ_N_OUT)
        else $error("level interrupt not asserted");
    AST_EDGE_PULSE: assert property (
        req_rise && edge_sel_ff |=> !IRQ_N_OUT)
        else $error("edge pulse missing");
    AST_EDGE_RETURN: assert property (
        edge_sel_ff && pulse_cnt_ff == '0 && !req_rise |=> IRQ_N_OUT)
        else $error("edge pulse did not return high");
    AST_GATE_PENDING: assert property (
        $rose(global_interrupt_gate_ff) && (|(int_status_ff & int_mask_ff)) |=> !IRQ_N_OUT)
        else $error("pending interrupt not raised on gate set");
    AST_MASKED_QUIET: assert property (
        !edge_sel_ff && (int_status_ff & int_mask_ff) == '0 |=> IRQ_N_OUT)
        else $error("masked status raised the interrupt");
    AST_OC_KEEP: assert property (
        MODE_RESET_IN && !hw_rst && !bus_wr |=> $stable(out_ctl_ff))
        else $error("output control changed on mode reset");
    AST_OC_CASCADE: assert property (
        bus_wr && sel == SEL_OUT_CTRL && WB_SEL_IN[LOW_LANE] && !hw_rst
        |=> out_ctl_ff == $past(WB_DAT_IN[OC_W-1:0]))
        else $error("output control write lost");
    AST_HW_BUSY: assert property (
        hw_rst |=> out_ctl_ff[OC_BUSY_BIT] ##1 !BUSY_N_OUT)
        else $error("hardware reset did not force busy");
    AST_PULLUP: assert property (
        1'b1 |=> PULLUP_EN_OUT == !($past(out_ctl_ff[OC_PUDIS_BIT]) || $past(if_cfg)))
        else $error("pull-up enable wrong");
    AST_TURBO: assert property (
        rd_both && out_ctl_ff[OC_TURBO_BIT] |=> READ_BUF_EN_OUT)
        else $error("turbo read buffer late");
    AST_NORMAL: assert property (
        $rose(rd_both) && !out_ctl_ff[OC_TURBO_BIT] |=> !READ_BUF_EN_OUT)
        else $error("normal read buffer too early");
    AST_RESERVED: assert property (
        WB_ACK_OUT && sel == SEL_INT_STAT |-> WB_DAT_OUT[DATA_W-1:NUM_SRC] == '0)
        else $error("reserved status bits not zero");

    COV_EDGE: cover property (req_rise && edge_sel_ff ##1 !IRQ_N_OUT ##2 IRQ_N_OUT);
    COV_LEVEL: cover property (!IRQ_N_OUT && !edge_sel_ff ##1 IRQ_N_OUT);
    COV_BOOT: cover property (!BUSY_N_OUT ##1 BOOT_DONE_IN);
    COV_TURBO: cover property (READ_BUF_EN_OUT && out_ctl_ff[OC_TURBO_BIT]);
endmodule : flash_irq_ctrl

// file: testbench/host_model.sv
/*
 * Host side of the interrupt pin: counts low pulses on the pin and their length.
 * Assumes the pin is sampled on the device clock.
 */
`timescale 1ns/1ps
module host_model (
    input  wire logic clk_in,
    input  wire logic irq_n_in,
    output int        pulses_out,
    output int        low_len_out
);
    int run = 0;
    initial pulses_out = 0;
    initial low_len_out = 0;
    // Length is known only once the pin returns high
    always @(posedge clk_in) begin
        if (irq_n_in === 1'b0) begin
            run <= run + 1;
        end else begin
            if (run > 0) begin
                pulses_out <= pulses_out + 1;
                low_len_out <= run;
            end
            run <= 0;
        end
    end
endmodule : host_model

// file: testbench/flash_irq_ctrl_bench.sv
/*
 * Self-checking bench of the interrupt and output control block.
 * Assumes the 1-cycle Wishbone answer and the pin synchronisers of the design.
 */
`timescale 1ns/1ps
module flash_irq_ctrl_bench;
    import flash_irq_pkg::*;
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, mode = 0, hw_n = 1, done = 0;
    logic        oe_n = 1, ce_n = 1, ifc = 0, sb = 0, ack, irq_n, busy_n, pu_en, rbe, intr;
    logic [15:0] adr = '0;
    logic [31:0] wd = '0, rd, q;
    logic [5:0]  src = '0;
    logic [1:0]  casc = '0;
    int          err_total = 0, comparisons = 0, pulses, low_len, t0, t1;
    always #25 clk = ~clk;
    flash_irq_ctrl i_flash_irq_ctrl (.CLOCK_IN(clk), .RESET_IN(rst), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'h3), .WB_DAT_IN(wd),
        .WB_DAT_OUT(rd), .WB_ACK_OUT(ack), .SOURCE_IN(src), .MODE_RESET_IN(mode),
        .SOFT_BOOT_START_IN(sb), .BOOT_DONE_IN(done), .DEVICE_ID_IN(2'h0),
        .HARDWARE_RESET_PIN_N_IN(hw_n), .IF_CFG_IN(ifc), .OE_N_IN(oe_n), .CE_N_IN(ce_n),
        .CASCADE_SELECT_PINS_IN(casc), .IRQ_N_OUT(irq_n), .BUSY_N_OUT(busy_n),
        .PULLUP_EN_OUT(pu_en), .READ_BUF_EN_OUT(rbe), .INT_OUT(intr));
    host_model i_host_model (.clk_in(clk), .irq_n_in(irq_n), .pulses_out(pulses),
        .low_len_out(low_len));
    task tally_and_finish;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Request held until ack is sampled, then idle one cycle
    task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wd <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        if (n == 20) begin
            err_total++;
            tally_and_finish();
        end
        q = rd;
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask : wb
    task rc(input logic [15:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask : rc
    task pulse(input logic [5:0] m);
        src <= m;
        @(posedge clk);
        src <= 6'h00;
        repeat (3) @(posedge clk);
    endtask : pulse
    task t_sources;
        for (int i = 0; i < NUM_SRC; i++) begin
            wb(1'b1, INT_CTRL_ADDR, 32'h8000 | (32'h1 << i) | (32'h100 << i));
            pulse(6'h3F);
            rc(INT_STAT_ADDR, 32'h1 << i, "status");
            repeat (10) @(posedge clk);
            chk("irq level", irq_n, 1'b0);
            wb(1'b1, INT_CTRL_ADDR, 32'h8000 | (32'h100 << i));
            rc(INT_STAT_ADDR, 32'h0, "cleared");
            wb(1'b1, INT_CTRL_ADDR, 32'h8000 | (32'h1 << i) | (32'h100 << i));
            chk("irq cleared", irq_n, 1'b1);
        end
    endtask : t_sources
    task t_mask_gate;
        wb(1'b1, INT_CTRL_ADDR, 32'h8001);
        pulse(6'h01);
        chk("unmasked", irq_n, 1'b1);
        wb(1'b1, INT_CTRL_ADDR, 32'h0101);
        repeat (2) @(posedge clk);
        chk("gated", irq_n, 1'b1);
        wb(1'b1, INT_CTRL_ADDR, 32'h8101);
        repeat (2) @(posedge clk);
        chk("gate on", irq_n, 1'b0);
        wb(1'b1, INT_CTRL_ADDR, 32'h0);
    endtask : t_mask_gate
    task t_edge;
        // Let the host count the level pulse that the previous scenario ended
        repeat (2) @(posedge clk);
        t0 = pulses;
        wb(1'b1, INT_CTRL_ADDR, 32'hC101);
        pulse(6'h01);
        repeat (6) @(posedge clk);
        chk("pulses", pulses, t0 + 1);
        chk("pulse len", low_len, IRQ_PULSE_CYC);
        chk("irq back", irq_n, 1'b1);
        wb(1'b1, INT_CTRL_ADDR, 32'h4101);
        wb(1'b1, INT_CTRL_ADDR, 32'hC101);
        repeat (6) @(posedge clk);
        chk("gate pulse", pulses, t0 + 2);
    endtask : t_edge
    task t_regs;
        wb(1'b1, INT_CTRL_ADDR, 32'hFFFF);
        rc(INT_CTRL_ADDR, 32'hFF3F, "ctl bits");
        wb(1'b1, OUT_CTRL_ADDR, 32'hFF);
        rc(OUT_CTRL_ADDR, 32'h7, "out bits");
        mode <= 1;
        @(posedge clk);
        mode <= 0;
        rc(INT_CTRL_ADDR, 32'h0, "mode ctl");
        rc(OUT_CTRL_ADDR, 32'h7, "mode out");
        casc <= 2'h1;
        repeat (6) @(posedge clk);
        wb(1'b1, INT_CTRL_ADDR, 32'h8101);
        wb(1'b1, OUT_CTRL_ADDR, 32'h1);
        casc <= 2'h0;
        repeat (6) @(posedge clk);
        rc(INT_CTRL_ADDR, 32'h0, "casc ctl");
        rc(OUT_CTRL_ADDR, 32'h1, "casc out");
    endtask : t_regs
    task meas(output int c);
        oe_n <= 0;
        ce_n <= 0;
        for (c = 0; c < 30; c++) begin
            @(posedge clk);
            if (rbe === 1'b1) break;
        end
        if (c == 30) begin
            err_total++;
            tally_and_finish();
        end
        oe_n <= 1;
        ce_n <= 1;
        repeat (8) @(posedge clk);
    endtask : meas
    task t_pins;
        repeat (6) @(posedge clk);
        chk("pullup", pu_en, 1'b1);
        ifc <= 1;
        repeat (6) @(posedge clk);
        chk("pullup cfg", pu_en, 1'b0);
        ifc <= 0;
        wb(1'b1, OUT_CTRL_ADDR, 32'h3);
        repeat (6) @(posedge clk);
        chk("pullup dis", pu_en, 1'b0);
        wb(1'b1, OUT_CTRL_ADDR, 32'h5);
        meas(t0);
        wb(1'b1, OUT_CTRL_ADDR, 32'h1);
        meas(t1);
        chk("settle", t1 - t0, SETTLE_CYC);
    endtask : t_pins
    task t_hwrst;
        wb(1'b1, OUT_CTRL_ADDR, 32'h6);
        hw_n <= 0;
        repeat (8) @(posedge clk);
        chk("busy", busy_n, 1'b0);
        hw_n <= 1;
        repeat (8) @(posedge clk);
        rc(OUT_CTRL_ADDR, 32'h1, "hw out");
        chk("busy held", busy_n, 1'b0);
        done <= 1;
        @(posedge clk);
        done <= 0;
        repeat (4) @(posedge clk);
        chk("busy end", busy_n, 1'b1);
    endtask : t_hwrst
    // Soft-reset download: busy follows output control bit 0
    task t_soft;
        for (int b = 1; b >= 0; b--) begin
            wb(1'b1, OUT_CTRL_ADDR, b);
            sb <= 1;
            @(posedge clk);
            sb <= 0;
            repeat (3) @(posedge clk);
            chk("soft busy", busy_n, !b);
            done <= 1;
            @(posedge clk);
            done <= 0;
            repeat (3) @(posedge clk);
        end
    endtask : t_soft
    // Unmapped access raises the event bit; mask and write-one-to-clear
    task t_events;
        rc(16'h1040, 32'h0, "unmapped");
        repeat (2) @(posedge clk);
        chk("evt masked", intr, 1'b0);
        wb(1'b1, EVT_MASK_ADDR, 32'h4);
        repeat (2) @(posedge clk);
        chk("evt raised", intr, 1'b1);
        wb(1'b1, EVT_STAT_ADDR, 32'h4);
        repeat (2) @(posedge clk);
        chk("evt cleared", intr, 1'b0);
        rc(EVT_STAT_ADDR, 32'h3, "evt left");
    endtask : t_events
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rc(INT_CTRL_ADDR, 32'h0, "rst ctl");
        rc(INT_STAT_ADDR, 32'h0, "rst stat");
        rc(OUT_CTRL_ADDR, 32'h1, "rst out");
        t_sources();
        t_mask_gate();
        t_edge();
        t_regs();
        t_pins();
        t_hwrst();
        t_soft();
        t_events();
        tally_and_finish();
    end
endmodule : flash_irq_ctrl_bench
